/* pkg/wdc_defines.svh */
// Offsets, field positions, reset values and cycle counts for the
// configuration and watchdog block.
// Assumes inclusion by bare name from the design module and the testbench.
`ifndef WDC_DEFINES_SVH
`define WDC_DEFINES_SVH

// Register addresses on the internal register bus
`define WDC_ADDR_OPT_SECOND 16'h001e
`define WDC_ADDR_OPT_FIRST 16'h001f
`define WDC_ADDR_SERVICE 16'hffff

// Second option register field positions
`define WDC_O2_PULLUP_OFF 7
`define WDC_O2_IRQ_ON 6
`define WDC_O2_OSC_HI 4
`define WDC_O2_OSC_LO 3
`define WDC_O2_RSTPIN_ON 0
`define WDC_O2_MASK 8'hd9

// First option register field positions
`define WDC_O1_PERIOD_SEL 7
`define WDC_O1_LVM_IN_STOP 6
`define WDC_O1_LVM_RST_OFF 5
`define WDC_O1_LVM_PWR_OFF 4
`define WDC_O1_LVM_FIVE 3
`define WDC_O1_SHORT_REC 2
`define WDC_O1_STOP_EN 1
`define WDC_O1_WDOG_OFF 0

// Reset values; only the power-on-only bits survive other resets
`define WDC_OPT_RESET 8'h00
`define WDC_O2_KEEP_MASK 8'h01
`define WDC_O1_KEEP_MASK 8'h08

// Cycle counts in fast-clock cycles; the wakeup count in wakeup-oscillator ticks
`define WDC_REC_SHORT_CYC 13'd32
`define WDC_REC_LONG_CYC 13'd4096
`define WDC_RSTPIN_LOW_CYC 6'd32
`define WDC_WAKE_SHORT_TICKS 15'd512

`endif

/* pkg/wdc_pkg.sv */
// Types for the configuration and watchdog block: state machine and state record.
// Assumes the defines header is on the include path.
package wdc_pkg;

  // Run, stopped, or waiting out the stop recovery delay
  typedef enum logic [1:0] {
    WDC_RUN,
    WDC_STOP,
    WDC_RECOVER
  } wdc_mode_t;

  // Whole state of the block in one record
  typedef struct packed {
    wdc_mode_t mode;
    logic [7:0] opt_first;
    logic [7:0] opt_second;
    logic first_written;
    logic second_written;
    logic [11:0] prescale;
    logic [5:0] wdog_count;
    logic [12:0] recover_count;
    logic recover_long;
    logic [14:0] wake_count;
    logic [5:0] rstpin_count;
    logic rstpin_oe;
    logic wdog_reset;
    logic wdog_cause_flag;
    logic [7:0] rdata;
    logic pullup_en;
    logic irq_function_en;
    logic [1:0] osc_source;
    logic reset_pin_function_en;
    logic lvm_power_en;
    logic lvm_reset_en;
    logic lvm_run_in_stop;
    logic lvm_five_volt;
    logic stop_insn_en;
    logic illegal_opcode;
    logic wake_request;
    logic stop_exit_done;
    logic wdog_enabled;
    logic in_stop;
  } wdc_state_t;

endpackage

/* design/wdc_config_watchdog.sv */
// Write-once system option registers and the watchdog with its prescaler.
// Assumes a synchronous register bus, a fast clock at 25 MHz, rst_n as the
// power-on reset, and other reset sources arriving as a synchronous request.
//
// Operation
// - One write per reset, readable always
// - Reset pin bit cleared only at power-on
// - Five-volt mode bit cleared only at power-on
// - Pullup-off bit disconnects the interrupt pin pullup
// - Interrupt pin function enabled by its bit
// - Two bits select the oscillator source
// - Reset pin function enabled by its bit
// - Period bit picks 8176 or 262128 cycles
// - In stop, 512 or 16384 wakeup ticks
// - Monitor runs in stop if enabled, powered
// - Monitor reset-off bit blocks monitor resets
// - Monitor power-off bit powers monitor down
// - Voltage bit selects five or three volt
// - Stop recovery waits 32 or 4096 cycles
// - Monitor-caused stop exit always recovers long
// - Stop disabled means illegal opcode
// - Watchdog disable bit turns watchdog off
// - Six-bit counter after prescaler, overflow resets
// - Watchdog reset drives pin, sets cause flag
// - Service address reads reset vector low byte
// - Stop instruction clears the prescaler
`timescale 1ns/100ps
`include "wdc_defines.svh"

// Design notes
// - The watchdog is one 18-bit chain: the low twelve bits are the system
//   prescale counter and the top six bits the watchdog counter proper, so a
//   single adder carries the prescaler into the watchdog.
// - Overflow is taken one count early so that the reset request pulse
//   appears after exactly the selected number of counting cycles.
// - A service write clears the watchdog bits and the upper eight prescale
//   bits only; the low four prescale bits keep running, so the next timeout
//   may come up to fifteen cycles early. Software must allow for that.
// - Watchdog overflow also acts as an internal reset of this block. Only the
//   reset-pin function bit and the five-volt monitor bit survive it.
// - The cause flag and the reset-pin stretch counter are deliberately left
//   out of the internal reset, so the pin stays low across the reset it
//   announces and software can still see why it restarted.
// - The wakeup timer only advances on wakeup-oscillator ticks; the tick is
//   expected to be synchronised to the fast clock by the caller.
// - The watchdog is idle in stop and resumes during stop recovery.
// - Clock enable low holds every flop, including pulses in flight, so a
//   pulse output may stand for longer than one clock while frozen.
// - Reads have no side effects; a read of the service address returns the
//   reset vector byte supplied from outside and never any watchdog state.
// - The second option register only stores its defined bits; the others
//   are masked on write and always read back as zero.
// - A stop instruction with stop disabled gives a one-cycle illegal opcode
//   pulse and leaves the mode unchanged.
// - A monitor trip during stop takes priority over an ordinary wake and
//   always uses the long recovery delay.

module wdc_config_watchdog #(
  // Watchdog timeouts in fast-clock cycles
  parameter logic [17:0] WDOG_LONG_CYC = 18'd262128,
  parameter logic [17:0] WDOG_SHORT_CYC = 18'd8176,
  // Long wakeup period in wakeup-oscillator ticks
  parameter logic [14:0] WAKE_LONG_TICKS = 15'd16384
) (
  // Clock, power-on reset, clock enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register bus
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // Reset vector low byte, returned on a service-address read
  input wire logic [7:0] reset_vec_lo,
  // Other reset sources and reset cause flag handling
  input wire logic sys_reset_req,
  input wire logic cause_flag_clear,
  output logic wdog_cause_flag,
  output logic wdog_reset,
  // Reset pin, open drain
  output logic rstpin_out,
  output logic rstpin_oe,
  // Stop mode
  input wire logic stop_insn,
  input wire logic stop_wake,
  input wire logic lvm_trip,
  input wire logic wakeup_osc_tick,
  output logic illegal_opcode,
  output logic wake_request,
  output logic stop_exit_done,
  output logic in_stop,
  // Option outputs
  output logic irq_pullup_en,
  output logic irq_function_en,
  output logic [1:0] osc_source,
  output logic reset_pin_function_en,
  output logic lvm_power_en,
  output logic lvm_reset_en,
  output logic lvm_run_in_stop,
  output logic lvm_five_volt,
  output logic stop_insn_en,
  output logic wdog_enabled
);

  // Current and next state record
  wdc_pkg::wdc_state_t st;
  wdc_pkg::wdc_state_t next_st;

  // Last count value before the watchdog overflows
  function automatic logic [17:0] wdog_limit(input logic short_sel);
    if (short_sel) begin
      wdog_limit = WDOG_SHORT_CYC - 18'd1;
    end else begin
      wdog_limit = WDOG_LONG_CYC - 18'd1;
    end
  endfunction

  // Last recovery count before the core resumes
  function automatic logic [12:0] recover_limit(input logic long_sel);
    if (long_sel) begin
      recover_limit = `WDC_REC_LONG_CYC - 13'd1;
    end else begin
      recover_limit = `WDC_REC_SHORT_CYC - 13'd1;
    end
  endfunction

  // Last wakeup tick count before a wakeup request
  function automatic logic [14:0] wake_limit(input logic short_sel);
    if (short_sel) begin
      wake_limit = `WDC_WAKE_SHORT_TICKS - 15'd1;
    end else begin
      wake_limit = WAKE_LONG_TICKS - 15'd1;
    end
  endfunction

  // Bus decode helpers
  logic wr_first;
  logic wr_second;
  logic wr_service;
  logic wdog_timeout;
  logic other_reset;

  // Address decode for writes
  // Reads are decoded in the next-state logic instead
  always_comb begin
    wr_first = 1'b0;
    wr_second = 1'b0;
    wr_service = 1'b0;
    if (bus_wr && bus_addr == `WDC_ADDR_OPT_FIRST) begin
      wr_first = 1'b1;
    end else if (bus_wr && bus_addr == `WDC_ADDR_OPT_SECOND) begin
      wr_second = 1'b1;
    end else if (bus_wr && bus_addr == `WDC_ADDR_SERVICE) begin
      wr_service = 1'b1;
    end
  end

  // Overflow only while counting; a service write in the same cycle wins
  // The compare spans the whole 18-bit chain, not the watchdog bits alone
  always_comb begin
    wdog_timeout = !st.opt_first[`WDC_O1_WDOG_OFF] && st.mode != wdc_pkg::WDC_STOP &&
      {st.wdog_count, st.prescale} >= wdog_limit(st.opt_first[`WDC_O1_PERIOD_SEL]) && !wr_service;
    other_reset = sys_reset_req || wdog_timeout;
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    // One-cycle outputs fall back each cycle
    next_st.rdata = 8'h00;
    next_st.illegal_opcode = 1'b0;
    next_st.wake_request = 1'b0;
    next_st.stop_exit_done = 1'b0;
    next_st.wdog_reset = 1'b0;

    // Register reads; data stand only in the following cycle
    // Masked bits were never stored, so they read back as zero
    if (bus_rd) begin
      if (bus_addr == `WDC_ADDR_OPT_FIRST) begin
        next_st.rdata = st.opt_first;
      end else if (bus_addr == `WDC_ADDR_OPT_SECOND) begin
        next_st.rdata = st.opt_second;
      end else if (bus_addr == `WDC_ADDR_SERVICE) begin
        next_st.rdata = reset_vec_lo;
      end else begin
        // Unmapped reads return zero
        next_st.rdata = 8'h00;
      end
    end

    // Single permitted write per register since the last reset
    // A refused write leaves both the value and its flag untouched
    if (wr_first && !st.first_written) begin
      next_st.opt_first = bus_wdata;
      next_st.first_written = 1'b1;
    end
    if (wr_second && !st.second_written) begin
      next_st.opt_second = bus_wdata & `WDC_O2_MASK;
      next_st.second_written = 1'b1;
    end

    // Watchdog chain: prescaler feeds the six-bit counter
    // Held while disabled or stopped; counting resumes in recovery
    if (!st.opt_first[`WDC_O1_WDOG_OFF] && st.mode != wdc_pkg::WDC_STOP) begin
      {next_st.wdog_count, next_st.prescale} = {st.wdog_count, st.prescale} + 18'd1;
    end
    if (wr_service) begin
      // Keep the low prescale stages so bus timing is not disturbed
      next_st.wdog_count = 6'd0;
      next_st.prescale[11:4] = 8'h00;
    end

    // Mode machine
    // Other resets force run further down
    case (st.mode)
      wdc_pkg::WDC_RUN: begin
        // A stop instruction either parks the core or is refused
        if (stop_insn) begin
          if (st.opt_first[`WDC_O1_STOP_EN]) begin
            next_st.mode = wdc_pkg::WDC_STOP;
            next_st.prescale = 12'h000;
            next_st.wake_count = 15'd0;
          end else begin
            next_st.illegal_opcode = 1'b1;
          end
        end
      end
      wdc_pkg::WDC_STOP: begin
        // Wakeup timer runs on the wakeup oscillator ticks only
        if (wakeup_osc_tick) begin
          if (st.wake_count >= wake_limit(st.opt_first[`WDC_O1_PERIOD_SEL])) begin
            next_st.wake_count = 15'd0;
            next_st.wake_request = 1'b1;
          end else begin
            next_st.wake_count = st.wake_count + 15'd1;
          end
        end
        if (lvm_trip) begin
          // Monitor exits always take the long delay
          next_st.mode = wdc_pkg::WDC_RECOVER;
          next_st.recover_long = 1'b1;
          next_st.recover_count = 13'd0;
        end else if (stop_wake) begin
          // An ordinary wake honours the short recovery bit
          next_st.mode = wdc_pkg::WDC_RECOVER;
          next_st.recover_long = !st.opt_first[`WDC_O1_SHORT_REC];
          next_st.recover_count = 13'd0;
        end
      end
      wdc_pkg::WDC_RECOVER: begin
        // Count out the recovery delay, then resume running
        if (st.recover_count >= recover_limit(st.recover_long)) begin
          next_st.mode = wdc_pkg::WDC_RUN;
          next_st.stop_exit_done = 1'b1;
        end else begin
          next_st.recover_count = st.recover_count + 13'd1;
        end
      end
      default: begin
        // Unused encoding falls back to run
        next_st.mode = wdc_pkg::WDC_RUN;
      end
    endcase

    // Reset pin stretch; survives the internal reset it announces
    // Loaded on overflow below and counted down to zero here
    if (st.rstpin_count != 6'd0) begin
      next_st.rstpin_count = st.rstpin_count - 6'd1;
    end
    next_st.rstpin_oe = next_st.rstpin_count != 6'd0;

    // Any reset other than power-on
    // Counters other than the reset pin stretch and write-once flags restart; power-on-only bits are kept
    if (other_reset) begin
      next_st.mode = wdc_pkg::WDC_RUN;
      next_st.prescale = 12'h000;
      next_st.wdog_count = 6'd0;
      next_st.recover_count = 13'd0;
      next_st.wake_count = 15'd0;
      next_st.first_written = 1'b0;
      next_st.second_written = 1'b0;
      next_st.opt_first = st.opt_first & `WDC_O1_KEEP_MASK;
      next_st.opt_second = st.opt_second & `WDC_O2_KEEP_MASK;
      next_st.illegal_opcode = 1'b0;
      next_st.wake_request = 1'b0;
      next_st.stop_exit_done = 1'b0;
    end
    // The pin is only pulled when its reset function is enabled
    if (wdog_timeout) begin
      next_st.wdog_reset = 1'b1;
      if (st.opt_second[`WDC_O2_RSTPIN_ON]) begin
        next_st.rstpin_count = `WDC_RSTPIN_LOW_CYC;
        next_st.rstpin_oe = 1'b1;
      end
    end

    // Cause flag: a new watchdog reset wins over a clear
    // Other resets leave the flag alone so software can read the cause
    if (wdog_timeout) begin
      next_st.wdog_cause_flag = 1'b1;
    end else if (cause_flag_clear) begin
      next_st.wdog_cause_flag = 1'b0;
    end

    // Registered option outputs follow the next stored values
    // Decoded here so every output comes straight from a flop
    next_st.pullup_en = !next_st.opt_second[`WDC_O2_PULLUP_OFF];
    next_st.irq_function_en = next_st.opt_second[`WDC_O2_IRQ_ON];
    next_st.osc_source = {next_st.opt_second[`WDC_O2_OSC_HI], next_st.opt_second[`WDC_O2_OSC_LO]};
    next_st.reset_pin_function_en = next_st.opt_second[`WDC_O2_RSTPIN_ON];
    next_st.lvm_power_en = !next_st.opt_first[`WDC_O1_LVM_PWR_OFF];
    next_st.lvm_reset_en = !next_st.opt_first[`WDC_O1_LVM_RST_OFF];
    next_st.lvm_run_in_stop = next_st.opt_first[`WDC_O1_LVM_IN_STOP] &&
      !next_st.opt_first[`WDC_O1_LVM_PWR_OFF];
    next_st.lvm_five_volt = next_st.opt_first[`WDC_O1_LVM_FIVE];
    next_st.stop_insn_en = next_st.opt_first[`WDC_O1_STOP_EN];
    next_st.wdog_enabled = !next_st.opt_first[`WDC_O1_WDOG_OFF];
    // Stop status registered like the option outputs
    next_st.in_stop = next_st.mode == wdc_pkg::WDC_STOP;

    // Clock enable low freezes everything
    // Placed last so it overrides every assignment above
    if (!clk_en) begin
      next_st = st;
    end
  end

  // State register; power-on reset loads constants only
  // Reset levels of the option outputs match a cleared option record
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mode <= wdc_pkg::WDC_RUN;
      st.opt_first <= `WDC_OPT_RESET;
      st.opt_second <= `WDC_OPT_RESET;
      st.pullup_en <= 1'b1;
      st.lvm_power_en <= 1'b1;
      st.lvm_reset_en <= 1'b1;
      st.wdog_enabled <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state record
  // Every output below except the constant rstpin_out is a flop of the record, never a decode
  assign bus_rdata = st.rdata;
  assign wdog_cause_flag = st.wdog_cause_flag;
  assign wdog_reset = st.wdog_reset;
  // Open-drain pin only ever pulls low
  assign rstpin_out = 1'b0;
  assign rstpin_oe = st.rstpin_oe;
  assign illegal_opcode = st.illegal_opcode;
  assign wake_request = st.wake_request;
  assign stop_exit_done = st.stop_exit_done;
  assign in_stop = st.in_stop;
  assign irq_pullup_en = st.pullup_en;
  assign irq_function_en = st.irq_function_en;
  assign osc_source = st.osc_source;
  assign reset_pin_function_en = st.reset_pin_function_en;
  assign lvm_power_en = st.lvm_power_en;
  assign lvm_reset_en = st.lvm_reset_en;
  assign lvm_run_in_stop = st.lvm_run_in_stop;
  assign lvm_five_volt = st.lvm_five_volt;
  assign stop_insn_en = st.stop_insn_en;
  assign wdog_enabled = st.wdog_enabled;

endmodule

/* tb/wdc_props.sv */
// Port-level checks for the option registers and watchdog.
// Assumes one clock domain with rst_n as the only reset seen here.
`timescale 1ns/100ps
module wdc_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register bus
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [7:0] reset_vec_lo,
  // Watchdog and reset pin
  input wire logic wdog_reset,
  input wire logic wdog_cause_flag,
  input wire logic wdog_enabled,
  input wire logic reset_pin_function_en,
  input wire logic rstpin_out,
  input wire logic rstpin_oe,
  // Stop control
  input wire logic stop_insn,
  input wire logic stop_insn_en,
  input wire logic sys_reset_req,
  input wire logic in_stop,
  input wire logic illegal_opcode,
  input wire logic stop_exit_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Cycles the pin has been held low so far
  logic [6:0] pin_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_cnt <= 7'h00;
    end else begin
      pin_cnt <= rstpin_oe ? pin_cnt + 7'h01 : 7'h00;
    end
  end
  rd_idle_a: assert property ($past(clk_en) && !$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data not idle");
  svc_read_a: assert property ($past(clk_en) && $past(bus_rd) && $past(bus_addr) == 16'hffff
    |-> bus_rdata == $past(reset_vec_lo)) else $error("service read not vector byte");
  flag_set_a: assert property (wdog_reset |-> ##[0:1] wdog_cause_flag)
    else $error("cause flag not set");
  pin_start_a: assert property (wdog_reset && reset_pin_function_en |-> ##[0:1] rstpin_oe)
    else $error("pin not driven");
  pin_len_a: assert property (rstpin_oe |-> pin_cnt < 7'd32 && rstpin_out == 1'b0)
    else $error("pin stretch wrong");
  wdog_off_a: assert property (wdog_reset |-> $past(wdog_enabled))
    else $error("reset while disabled");
  stop_bad_a: assert property (stop_insn && clk_en && !stop_insn_en && !in_stop && !sys_reset_req
    |=> illegal_opcode && !in_stop) else $error("illegal stop not flagged");
  stop_go_a: assert property (stop_insn && clk_en && stop_insn_en && !in_stop && !sys_reset_req
    |=> in_stop && !illegal_opcode) else $error("stop not entered");
  cover property (wdog_reset);
  cover property ($rose(in_stop));
  cover property (stop_exit_done);
endmodule

bind wdc_config_watchdog wdc_props wdc_props_i (.core_clk, .rst_n, .clk_en, .bus_addr, .bus_rd, .bus_rdata,
  .reset_vec_lo, .wdog_reset, .wdog_cause_flag, .wdog_enabled, .reset_pin_function_en, .rstpin_out,
  .rstpin_oe, .stop_insn, .stop_insn_en, .sys_reset_req, .in_stop, .illegal_opcode, .stop_exit_done);

/* tb/test_wdc_config_watchdog.sv */
// Self-checking bench: option registers, watchdog timeouts, stop recovery.
// Assumes shortened watchdog and wakeup counts and the bound checker.
`timescale 1ns/100ps
`include "wdc_defines.svh"
module test_wdc_config_watchdog;
  localparam logic [15:0] A1 = `WDC_ADDR_OPT_FIRST;
  localparam logic [15:0] A2 = `WDC_ADDR_OPT_SECOND;
  localparam logic [15:0] AS = `WDC_ADDR_SERVICE;
  // Inputs; reset_vec_lo stays tied, clk_en is dropped once
  logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00, reset_vec_lo = 8'h5a;
  logic bus_wr = 1'b0, bus_rd = 1'b0, sys_reset_req = 1'b0, cause_flag_clear = 1'b0;
  logic stop_insn = 1'b0, stop_wake = 1'b0, lvm_trip = 1'b0, wakeup_osc_tick = 1'b1;
  // Outputs
  logic [7:0] bus_rdata;
  logic [1:0] osc_source;
  logic wdog_cause_flag, wdog_reset, rstpin_out, rstpin_oe, illegal_opcode, wake_request;
  logic stop_exit_done, in_stop, irq_pullup_en, irq_function_en, reset_pin_function_en;
  logic lvm_power_en, lvm_reset_en, lvm_run_in_stop, lvm_five_volt, stop_insn_en, wdog_enabled;
  int miscompares = 0, n_tests = 0, cyc = 0, n_rst = 0, n, r0;
  logic [7:0] d;

  always #20 core_clk = ~core_clk;

  wdc_config_watchdog #(.WDOG_LONG_CYC(18'd300), .WDOG_SHORT_CYC(18'd100), .WAKE_LONG_TICKS(15'd40))
    wdc_config_watchdog_i (.core_clk, .rst_n, .clk_en, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .reset_vec_lo, .sys_reset_req, .cause_flag_clear, .wdog_cause_flag, .wdog_reset, .rstpin_out, .rstpin_oe,
    .stop_insn, .stop_wake, .lvm_trip, .wakeup_osc_tick, .illegal_opcode, .wake_request, .stop_exit_done,
    .in_stop, .irq_pullup_en, .irq_function_en, .osc_source, .reset_pin_function_en, .lvm_power_en,
    .lvm_reset_en, .lvm_run_in_stop, .lvm_five_volt, .stop_insn_en, .wdog_enabled);

  // Hang guard and overflow pulse count
  always @(posedge core_clk) begin
    cyc++;
    n_rst += int'(wdog_reset === 1'b1);
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task rng(input int k, input int lo, input int hi);
    chk(8'(k >= lo && k <= hi), 8'h01);
  endtask

  task wr(input logic [15:0] a, input logic [7:0] v);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // Data sampled in the single cycle after the strobe
  task rd(input logic [15:0] a, output logic [7:0] v);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
    @(posedge core_clk);
  endtask

  task por;
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask

  // Edges until a pulse shows: 0 overflow, 1 wakeup, 2 stop exit
  task waitfor(input int s, input int lim, output int k);
    k = 0;
    while (!(s == 0 ? wdog_reset === 1'b1 : s == 1 ? wake_request === 1'b1 : stop_exit_done === 1'b1)
           && k < lim) begin
      @(posedge core_clk);
      #1 k++;
    end
  endtask

  task s_regs;
    logic [7:0] w;
    for (int k = 0; k < 4; k++) begin
      por();
      chk({4'h0, irq_pullup_en, lvm_power_en, lvm_reset_en, wdog_enabled}, 8'h0f);
      rd(A2, d);
      chk(d, 8'h00);
      w = {k[0], k[1], 1'b0, k[1:0], 2'b00, k[0]};
      wr(A2, w | 8'h26);
      wr(A2, ~w);
      rd(A2, d);
      chk(d, w);
      chk({6'h0, osc_source}, 8'(k));
      chk({5'h0, irq_pullup_en, irq_function_en, reset_pin_function_en}, {5'h0, ~w[7], w[6], w[0]});
      rd(AS, d);
      chk(d, 8'h5a);
    end
  endtask

  task s_keep;
    por();
    wr(A2, 8'h01);
    wr(A1, 8'h6e);
    chk({3'h0, lvm_reset_en, lvm_power_en, lvm_five_volt, stop_insn_en, lvm_run_in_stop}, 8'h0f);
    sys_reset_req <= 1'b1;
    @(posedge core_clk);
    sys_reset_req <= 1'b0;
    @(posedge core_clk);
    rd(A2, d);
    chk(d, 8'h01);
    rd(A1, d);
    chk(d, 8'h08);
    // Frozen clock: a write must not land
    clk_en <= 1'b0;
    wr(A2, 8'hc0);
    clk_en <= 1'b1;
    rd(A2, d);
    chk(d, 8'h01);
    wr(A1, 8'h50);
    chk({5'h0, lvm_power_en, lvm_run_in_stop, lvm_five_volt}, 8'h00);
    stop_insn <= 1'b1;
    @(posedge core_clk);
    stop_insn <= 1'b0;
    #1 chk({7'h0, illegal_opcode}, 8'h01);
    @(posedge core_clk);
  endtask

  task s_wdog;
    por();
    wr(A2, 8'h01);
    wr(A1, 8'h80);
    wr(AS, 8'h00);
    waitfor(0, 200, n);
    rng(n, 80, 104);
    chk({7'h0, wdog_cause_flag}, 8'h01);
    n = 0;
    repeat (40) begin
      n += int'(rstpin_oe === 1'b1);
      @(posedge core_clk);
      #1;
    end
    rng(n, 32, 32);
    @(posedge core_clk);
    cause_flag_clear <= 1'b1;
    wr(AS, 8'h00);
    cause_flag_clear <= 1'b0;
    chk({7'h0, wdog_cause_flag}, 8'h00);
    waitfor(0, 400, n);
    rng(n, 276, 304);
    @(posedge core_clk);
    #1 r0 = n_rst;
    @(posedge core_clk);
    repeat (8) begin
      wr(AS, 8'h00);
      repeat (60) @(posedge core_clk);
    end
    wr(A1, 8'h01);
    repeat (700) @(posedge core_clk);
    chk(8'(n_rst - r0), 8'h00);
  endtask

  task s_stop;
    por();
    wr(A1, 8'h07);
    stop_insn <= 1'b1;
    @(posedge core_clk);
    stop_insn <= 1'b0;
    waitfor(1, 80, n);
    chk({7'h0, in_stop}, 8'h01);
    rng(n, 36, 44);
    @(posedge core_clk);
    stop_wake <= 1'b1;
    @(posedge core_clk);
    stop_wake <= 1'b0;
    waitfor(2, 60, n);
    rng(n, 29, 35);
    @(posedge core_clk);
    stop_insn <= 1'b1;
    @(posedge core_clk);
    stop_insn <= 1'b0;
    lvm_trip <= 1'b1;
    stop_wake <= 1'b1;
    @(posedge core_clk);
    lvm_trip <= 1'b0;
    stop_wake <= 1'b0;
    waitfor(2, 4200, n);
    rng(n, 4092, 4100);
  endtask

  // Stop entry after a long run must restart the prescaler
  task s_stopclr;
    por();
    wr(A1, 8'h06);
    repeat (250) @(posedge core_clk);
    stop_insn <= 1'b1;
    @(posedge core_clk);
    stop_insn <= 1'b0;
    stop_wake <= 1'b1;
    @(posedge core_clk);
    stop_wake <= 1'b0;
    waitfor(0, 400, n);
    rng(n, 296, 304);
  endtask

  task test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    s_regs();
    s_keep();
    s_wdog();
    s_stop();
    s_stopclr();
    test_done();
  end
endmodule
